// ===== verilog/usb_device_address_register.sv
// Avalon-MM register slave of the peripheral controller with the device address logic
`timescale 1ns/1ps
`include "usb_addr_consts.svh"
module usb_device_address_register
  import usb_addr_pkg::*;
#(
  parameter int          ADDR_W  = 12,
  parameter logic [31:0] CHIP_ID = 32'h0000_a5a5 // Arbitrary identification value
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              usb_bus_reset_in,
  input  wire logic              status_ack_in,
  input  wire logic              token_valid_in,
  input  wire logic [6:0]        token_addr_in,
  input  wire logic [15:0]       frame_number_in,
  output logic                   token_match_out,
  output logic                   respond_enable_out,
  output logic      [6:0]        active_addr_out,
  output logic                   addr_pending_out
);
  localparam logic [31:0] M8  = 32'h0000_00ff;
  localparam logic [31:0] M16 = 32'h0000_ffff;
  localparam logic [31:0] M32 = 32'hffff_ffff;
  localparam slot_type SLOT_NONE  = 5'd0;
  localparam slot_type SLOT_ADDR  = 5'd1;
  localparam slot_type SLOT_MODE  = 5'd4;
  localparam slot_type SLOT_CHIP  = 5'd22;
  localparam slot_type SLOT_FRAME = 5'd23;
  localparam slot_type SLOT_LAST  = 5'd29;
  localparam int       FIRST_MEM  = 2;
  localparam int       LAST_MEM   = 29;

  // The word index needs byte address bits 11..2
  generate
    if (ADDR_W < 12) begin : g_addr_check
      $error("ADDR_W must be at least 12");
    end
  endgenerate

  // Offset index to storage slot; zero marks an unmapped word
  function automatic slot_type slot_of(input logic [9:0] idx);
    slot_type s;
    s = SLOT_NONE;
    case (idx)
      `OFS_USB_ADDRESS:     s = SLOT_ADDR;
      `OFS_EP_MAX_PACKET:   s = 5'd2;
      `OFS_EP_KIND:         s = 5'd3;
      `OFS_MODE_CONTROL:    s = SLOT_MODE;
      `OFS_IRQ_CONFIG:      s = 5'd5;
      `OFS_DEBUG_CONTROL:   s = 5'd6;
      `OFS_IRQ_ENABLE:      s = 5'd7;
      `OFS_IRQ_STATUS:      s = 5'd8;
      `OFS_BUF_BYTE_LEN:    s = 5'd9;
      `OFS_BUF_FILL:        s = 5'd10;
      `OFS_FIFO_DATA:       s = 5'd11;
      `OFS_EP_CTRL_FUNC:    s = 5'd12;
      `OFS_EP_SELECT:       s = 5'd13;
      `OFS_DMA_COMMAND:     s = 5'd14;
      `OFS_DMA_XFER_COUNT:  s = 5'd15;
      `OFS_DMA_CONFIG:      s = 5'd16;
      `OFS_DMA_HANDSHAKE:   s = 5'd17;
      `OFS_DMA_IRQ_REASON:  s = 5'd18;
      `OFS_DMA_IRQ_ENABLE:  s = 5'd19;
      `OFS_DMA_EP_SELECT:   s = 5'd20;
      `OFS_DMA_BURST_LEN:   s = 5'd21;
      `OFS_CHIP_ID:         s = SLOT_CHIP;
      `OFS_FRAME_NUMBER:    s = SLOT_FRAME;
      `OFS_SCRATCH_PAD:     s = 5'd24;
      `OFS_REG_UNLOCK:      s = 5'd25;
      `OFS_IRQ_PULSE_WIDTH: s = 5'd26;
      `OFS_TEST_MODE:       s = 5'd27;
      `OFS_HW_MODE:         s = 5'd28;
      `OFS_DUAL_ROLE:       s = SLOT_LAST;
      default:              s = SLOT_NONE;
    endcase
    return s;
  endfunction

  // Reset value, implemented width and access kind of each slot
  function automatic reg_desc_type desc_of(input slot_type s);
    reg_desc_type d;
    d = '{`RST_ZERO, 32'h0000_0000, acc_ro};
    case (s)
      SLOT_ADDR:  d = '{`RST_ZERO, M8, acc_rw}; // R2
      5'd2:       d = '{`RST_ZERO, M16, acc_rw};
      5'd3:       d = '{`RST_ZERO, M16, acc_rw};
      SLOT_MODE:  d = '{`RST_ZERO, M16, acc_rw};
      5'd5:       d = '{`RST_IRQ_CONFIG, M8, acc_rw};
      5'd6:       d = '{`RST_DEBUG_CONTROL, M16, acc_rw};
      5'd7:       d = '{`RST_ZERO, M32, acc_rw};
      5'd8:       d = '{`RST_ZERO, M32, acc_w1c};
      5'd9:       d = '{`RST_ZERO, M16, acc_rw};
      5'd10:      d = '{`RST_ZERO, M8, acc_rw};
      5'd11:      d = '{`RST_ZERO, M32, acc_rw};
      5'd12:      d = '{`RST_ZERO, M8, acc_rw};
      5'd13:      d = '{`RST_EP_SELECT, M8, acc_rw};
      5'd14:      d = '{`RST_DMA_COMMAND, M8, acc_wo};
      5'd15:      d = '{`RST_ZERO, M32, acc_rw};
      5'd16:      d = '{`RST_DMA_CONFIG, M16, acc_rw};
      5'd17:      d = '{`RST_DMA_HANDSHAKE, M8, acc_rw};
      5'd18:      d = '{`RST_ZERO, M16, acc_w1c};
      5'd19:      d = '{`RST_ZERO, M16, acc_rw};
      5'd20:      d = '{`RST_ZERO, M8, acc_rw};
      5'd21:      d = '{`RST_DMA_BURST_LEN, M16, acc_rw};
      SLOT_CHIP:  d = '{`RST_ZERO, M32, acc_ro};
      SLOT_FRAME: d = '{`RST_ZERO, M16, acc_ro};
      5'd24:      d = '{`RST_ZERO, M16, acc_rw};
      5'd25:      d = '{`RST_ZERO, M16, acc_wo};
      5'd26:      d = '{`RST_IRQ_PULSE_WIDTH, M16, acc_rw};
      5'd27:      d = '{`RST_ZERO, M8, acc_rw};
      5'd28:      d = '{`RST_ZERO, M32, acc_rw};
      SLOT_LAST:  d = '{`RST_DUAL_ROLE, M32, acc_rw};
      default:    d = '{`RST_ZERO, 32'h0000_0000, acc_ro};
    endcase
    return d;
  endfunction

  // Expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  addr_ctrl_if ctl ();

  logic         ack_r;
  logic         req;
  logic         wr_fire;
  slot_type     slot;
  reg_desc_type desc;
  logic [31:0]  wr_mask;
  logic [31:0]  rd_value;
  logic [31:0]  readdata_r;
  logic         soft_reset_r;
  logic         token_match_r;
  logic         respond_enable_r;
  logic [31:0]  regs_r [FIRST_MEM:LAST_MEM];

  // Every access takes two cycles: decode, then answer with waitrequest low
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign wr_fire             = avs_write_in & ack_r;
  assign slot                = slot_of(avs_address_in[11:2]);
  assign desc                = desc_of(slot);
  assign wr_mask             = lane_mask(avs_byteenable_in) & desc.mask;

  // Answer strobe; drops after each answered cycle so back-to-back works
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read source; write-only and unmapped words read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (slot == SLOT_ADDR) begin
      rd_value = {24'h00_0000, ctl.reg_value}; // R8
    end else if (slot == SLOT_CHIP) begin
      rd_value = CHIP_ID;
    end else if (slot == SLOT_FRAME) begin
      rd_value = {16'h0000, frame_number_in};
    end else if (slot != SLOT_NONE && (desc.acc == acc_rw || desc.acc == acc_w1c)) begin
      rd_value = regs_r[slot] & desc.mask;
    end
  end

  // Read data is captured in the decode cycle and stands while waitrequest is low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      readdata_r <= rd_value;
    end
  end
  assign avs_readdata_out = readdata_r;

  // Plain storage words; write-only words keep what was written but never show it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = FIRST_MEM; i <= LAST_MEM; i++) begin
        regs_r[i] <= desc_of(slot_type'(i)).rst;
      end
    end else if (wr_fire && slot >= 5'd2) begin
      unique case (desc.acc)
        acc_rw, acc_wo: regs_r[slot] <= (regs_r[slot] & ~wr_mask) | (avs_writedata_in & wr_mask);
        acc_w1c:        regs_r[slot] <= regs_r[slot] & ~(avs_writedata_in & wr_mask);
        acc_ro:         regs_r[slot] <= regs_r[slot];
      endcase
    end
  end

  // Soft reset is a one-cycle pulse after a mode write with the reset bit set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= wr_fire && slot == SLOT_MODE && avs_byteenable_in[0] &&
                      avs_writedata_in[`SOFT_RESET_POS];
    end
  end

  // Address register writes need the low byte lane
  assign ctl.sw_write   = wr_fire && slot == SLOT_ADDR && avs_byteenable_in[0]; // R1
  assign ctl.sw_wdata   = avs_writedata_in[7:0];
  assign ctl.bus_reset  = usb_bus_reset_in; // R3
  assign ctl.soft_reset = soft_reset_r; // R4
  assign ctl.status_ack = status_ack_in; // R7

  address_tracker u_tracker (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ctl    (ctl)
  );

  // Token match only while enabled and only on the active address
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      token_match_r    <= 1'b0;
      respond_enable_r <= 1'b0;
    end else begin
      token_match_r <= token_valid_in && ctl.reg_value[`DEV_ENABLE_POS] &&
                       token_addr_in == ctl.active_addr; // R5 R7
      respond_enable_r <= ctl.reg_value[`DEV_ENABLE_POS]; // R5
    end
  end

  assign token_match_out    = token_match_r;
  assign respond_enable_out = respond_enable_r;
  assign active_addr_out    = ctl.active_addr;
  assign addr_pending_out   = ctl.pending;
endmodule

// ===== verilog/usb_addr_consts.svh
// Register offsets, reset values and field positions of the peripheral address block
// Contract
// R1 - The address register holds the assigned device address and the enable flag in one writable byte.
// R2 - The enable flag sits at bit 7 and the address field in bits 6..0, all read/write, all reset to 0.
// R3 - The address field clears on a USB bus reset, a power-on reset and a soft reset.
// R4 - The enable flag clears on power-on or soft reset and keeps its value over a USB bus reset.
// R5 - While the enable flag is 0 the device answers no host traffic; setting it enables answers.
// R6 - Firmware answers an address request by writing the enabled address, then a zero-length status.
// R7 - Matching stays on the old address after the write and moves to the new one at the status ack.
// R8 - A read returns the written value as changed by resets, never the active address while pending.
`ifndef USB_ADDR_CONSTS_SVH
`define USB_ADDR_CONSTS_SVH
`define OFS_USB_ADDRESS     10'h200
`define OFS_EP_MAX_PACKET   10'h204
`define OFS_EP_KIND         10'h208
`define OFS_MODE_CONTROL    10'h20c
`define OFS_IRQ_CONFIG      10'h210
`define OFS_DEBUG_CONTROL   10'h212
`define OFS_IRQ_ENABLE      10'h214
`define OFS_IRQ_STATUS      10'h218
`define OFS_BUF_BYTE_LEN    10'h21c
`define OFS_BUF_FILL        10'h21e
`define OFS_FIFO_DATA       10'h220
`define OFS_EP_CTRL_FUNC    10'h228
`define OFS_EP_SELECT       10'h22c
`define OFS_DMA_COMMAND     10'h230
`define OFS_DMA_XFER_COUNT  10'h234
`define OFS_DMA_CONFIG      10'h238
`define OFS_DMA_HANDSHAKE   10'h23c
`define OFS_DMA_IRQ_REASON  10'h250
`define OFS_DMA_IRQ_ENABLE  10'h254
`define OFS_DMA_EP_SELECT   10'h258
`define OFS_DMA_BURST_LEN   10'h264
`define OFS_CHIP_ID         10'h270
`define OFS_FRAME_NUMBER    10'h274
`define OFS_SCRATCH_PAD     10'h278
`define OFS_REG_UNLOCK      10'h27c
`define OFS_IRQ_PULSE_WIDTH 10'h280
`define OFS_TEST_MODE       10'h284
`define OFS_HW_MODE         10'h300
`define OFS_DUAL_ROLE       10'h374
`define RST_ZERO            32'h0000_0000
`define RST_IRQ_CONFIG      32'h0000_00fc
`define RST_DEBUG_CONTROL   32'h0000_0008
`define RST_EP_SELECT       32'h0000_0020
`define RST_DMA_COMMAND     32'h0000_00ff
`define RST_DMA_CONFIG      32'h0000_0001
`define RST_DMA_HANDSHAKE   32'h0000_0004
`define RST_DMA_BURST_LEN   32'h0000_0004
`define RST_IRQ_PULSE_WIDTH 32'h0000_001e
`define RST_DUAL_ROLE       32'h0000_0086
`define DEV_ENABLE_POS      7
`define DEV_ADDR_MSB        6
`define SOFT_RESET_POS      4
`endif

// ===== verilog/usb_addr_pkg.sv
// Types shared by the peripheral address block
package usb_addr_pkg;
  typedef enum logic [3:0] {
    acc_rw  = 4'b0001,
    acc_ro  = 4'b0010,
    acc_wo  = 4'b0100,
    acc_w1c = 4'b1000
  } acc_type;
  typedef struct packed {
    logic [31:0] rst;
    logic [31:0] mask;
    acc_type     acc;
  } reg_desc_type;
  typedef logic [4:0] slot_type;
endpackage

// ===== verilog/addr_ctrl_if.sv
// Carrier between the register slave and the device address tracker
`timescale 1ns/1ps
interface addr_ctrl_if;
  logic       sw_write;    // One-cycle write of the address register
  logic [7:0] sw_wdata;
  logic       bus_reset;
  logic       soft_reset;
  logic       status_ack;
  logic [7:0] reg_value;
  logic [6:0] active_addr;
  logic       pending;
  modport ctrl (output sw_write, sw_wdata, bus_reset, soft_reset, status_ack,
                input  reg_value, active_addr, pending);
  modport tracker (input  sw_write, sw_wdata, bus_reset, soft_reset, status_ack,
                   output reg_value, active_addr, pending);
endinterface

// ===== verilog/address_tracker.sv
// Device address register with deferred activation of a new address
`timescale 1ns/1ps
`include "usb_addr_consts.svh"
module address_tracker
  import usb_addr_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    rst_in,
  addr_ctrl_if.tracker ctl
);
  logic       enable_r;
  logic [6:0] addr_field_r;
  logic [6:0] active_addr_r;
  logic       pending_r;

  // Enable flag survives a USB bus reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_r <= 1'b0; // R2
    end else if (ctl.soft_reset) begin
      enable_r <= 1'b0; // R4
    end else if (ctl.sw_write) begin
      enable_r <= ctl.sw_wdata[`DEV_ENABLE_POS]; // R1
    end
  end

  // Address field; a bus reset beats a write in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_field_r <= 7'h00; // R2
    end else if (ctl.soft_reset || ctl.bus_reset) begin
      addr_field_r <= 7'h00; // R3
    end else if (ctl.sw_write) begin
      addr_field_r <= ctl.sw_wdata[`DEV_ADDR_MSB:0]; // R1
    end
  end

  // Matching keeps the old address until the host acks the status packet
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_addr_r <= 7'h00;
      pending_r     <= 1'b0;
    end else if (ctl.soft_reset || ctl.bus_reset) begin
      active_addr_r <= 7'h00; // R3
      pending_r     <= 1'b0;
    end else if (ctl.sw_write) begin
      pending_r <= 1'b1; // R7
    end else if (ctl.status_ack && pending_r) begin
      active_addr_r <= addr_field_r; // R7
      pending_r     <= 1'b0;
    end
  end

  // Software sees the written value, not the active one
  assign ctl.reg_value   = {enable_r, addr_field_r}; // R8
  assign ctl.active_addr = active_addr_r;
  assign ctl.pending     = pending_r;
endmodule

// ===== bench/usb_addr_props.sv
// Port-level checks of the peripheral address block
`timescale 1ns/1ps
`include "usb_addr_consts.svh"
module usb_addr_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  input wire logic              usb_bus_reset_in,
  input wire logic              status_ack_in,
  input wire logic              token_valid_in,
  input wire logic [6:0]        token_addr_in,
  input wire logic              token_match_out,
  input wire logic              respond_enable_out,
  input wire logic [6:0]        active_addr_out,
  input wire logic              addr_pending_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic hit_addr;
  // Accepted access to the address word
  assign hit_addr = !avs_waitrequest_out && avs_address_in[11:2] == `OFS_USB_ADDRESS;
  property p_match;
    token_valid_in && token_addr_in == active_addr_out ##1 respond_enable_out
      |-> token_match_out;
  endproperty
  a_match: assert property (p_match) else $error("token missed");
  property p_silent;
    token_valid_in ##1 !respond_enable_out |-> !token_match_out;
  endproperty
  a_silent: assert property (p_silent) else $error("answer while off");
  property p_bus_rst;
    usb_bus_reset_in && !avs_write_in |=> active_addr_out == 7'h00 && !addr_pending_out;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset kept addr");
  property p_keep_en;
    usb_bus_reset_in && !avs_write_in && !$past(avs_write_in) && !$past(avs_write_in, 2)
      |=> $stable(respond_enable_out);
  endproperty
  a_keep_en: assert property (p_keep_en) else $error("bus reset hit enable");
  property p_ack;
    status_ack_in && addr_pending_out && !avs_write_in && !usb_bus_reset_in
      |=> !addr_pending_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack left pending");
  property p_hold;
    !status_ack_in && !usb_bus_reset_in && !avs_write_in && !$past(avs_write_in)
      |=> $stable(active_addr_out);
  endproperty
  a_hold: assert property (p_hold) else $error("early address switch");
  property p_pend;
    avs_write_in && hit_addr && avs_byteenable_in[0] && !usb_bus_reset_in
      |=> addr_pending_out;
  endproperty
  a_pend: assert property (p_pend) else $error("write not pending");
  property p_wait;
    $rose(avs_read_in) || $rose(avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("bad waitrequest");
  property p_width;
    avs_read_in && hit_addr |-> avs_readdata_out[31:8] == 24'h000000;
  endproperty
  a_width: assert property (p_width) else $error("address reg too wide");
  c_match: cover property (token_valid_in ##1 token_match_out);
  c_ack: cover property (status_ack_in && addr_pending_out);
  c_bus_rst: cover property (usb_bus_reset_in && respond_enable_out);
endmodule

// ===== bench/usb_host_model.sv
// Host-side model: status ack, tokens and bus reset toward the device
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       clk_in,
  output logic            status_ack_out,
  output logic            token_valid_out,
  output logic      [6:0] token_addr_out,
  output logic            bus_reset_out
);
  // Idle levels; address lines carry junk outside tokens
  initial begin
    status_ack_out = 1'h0;
    token_valid_out = 1'h0;
    token_addr_out = 7'h2a;
    bus_reset_out = 1'h0;
  end
  // Acks the empty status packet, promptly or after dly cycles
  task automatic ack(input int dly);
    repeat (dly) @(posedge clk_in);
    @(posedge clk_in);
    status_ack_out <= 1'h1;
    @(posedge clk_in);
    status_ack_out <= 1'h0;
    #1;
  endtask
  // Inverted address afterwards so a stale value cannot fake a match
  task automatic token(input logic [6:0] a);
    @(posedge clk_in);
    token_valid_out <= 1'h1;
    token_addr_out <= a;
    @(posedge clk_in);
    token_valid_out <= 1'h0;
    token_addr_out <= ~a;
    #1;
  endtask
  // Bus reset held for n cycles
  task automatic bus_reset(input int n);
    @(posedge clk_in);
    bus_reset_out <= 1'h1;
    repeat (n) @(posedge clk_in);
    bus_reset_out <= 1'h0;
    #1;
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench of the peripheral address register block
`timescale 1ns/1ps
module tb;
  import usb_addr_pkg::*;
  localparam logic [31:0] CHIP = 32'h0000_5a3c; // Arbitrary identification value
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} row_type;
  // Reads expect d; writes send d
  localparam row_type ROWS [23] = '{
    '{1'h0,12'h800,32'h0}, '{1'h0,12'h810,32'h0}, '{1'h0,12'h840,32'hfc},
    '{1'h0,12'h848,32'h8}, '{1'h0,12'h8b0,32'h20}, '{1'h0,12'h8c0,32'h0},
    '{1'h0,12'h8e0,32'h1}, '{1'h0,12'h8f0,32'h4}, '{1'h0,12'h990,32'h4},
    '{1'h0,12'h9c0,CHIP}, '{1'h0,12'h9d0,32'h3c5a}, '{1'h0,12'ha00,32'h1e},
    '{1'h0,12'hdd0,32'h86}, '{1'h1,12'h9e0,32'h12345678}, '{1'h0,12'h9e0,32'h5678},
    '{1'h1,12'h9d0,32'hffff}, '{1'h0,12'h9d0,32'h3c5a}, '{1'h1,12'hffc,32'h1},
    '{1'h0,12'hffc,32'h0}, '{1'h1,12'h8c0,32'h7}, '{1'h0,12'h8c0,32'h0},
    '{1'h1,12'h860,32'hffff}, '{1'h0,12'h860,32'h0}};
  logic        clk_in, rst_in, avs_read_in, avs_write_in;
  logic [11:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [3:0]  avs_byteenable_in;
  logic [15:0] frame_number_in;
  logic        avs_waitrequest_out, bus_rst, ack, tok_v, match, resp_en, pend;
  logic [6:0]  tok_a, act;
  int          n_errors = 0, checks = 0, cyc = 0;
  usb_device_address_register #(.ADDR_W(12), .CHIP_ID(CHIP)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .usb_bus_reset_in(bus_rst), .status_ack_in(ack), .token_valid_in(tok_v),
    .token_addr_in(tok_a), .frame_number_in(frame_number_in), .token_match_out(match),
    .respond_enable_out(resp_en), .active_addr_out(act), .addr_pending_out(pend));
  usb_host_model host_u (.clk_in(clk_in), .status_ack_out(ack), .token_valid_out(tok_v),
    .token_addr_out(tok_a), .bus_reset_out(bus_rst));
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // Watchdog: the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; waitrequest and read data are taken at the same rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic tok(input logic [6:0] a, input logic m);
    host_u.token(a);
    chk({31'h0, match}, {31'h0, m});
  endtask
  initial begin
    rst_in = 1'h1;
    avs_read_in = 1'h0;
    avs_write_in = 1'h0;
    avs_address_in = 12'h000;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    frame_number_in = 16'h3c5a;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'h0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) bus(1'h1, ROWS[i].a, ROWS[i].d);
      else rd(ROWS[i].a, ROWS[i].d);
    end
    // Old address keeps matching until the host acks the status packet
    bus(1'h1, 12'h800, 32'h85);
    rd(12'h800, 32'h85);
    chk({31'h0, pend}, 32'h1);
    tok(7'h00, 1'h1);
    tok(7'h05, 1'h0);
    host_u.ack(3);
    chk({25'h0, act}, 32'h5);
    tok(7'h05, 1'h1);
    // Enable cleared: own address is ignored
    bus(1'h1, 12'h800, 32'h05);
    host_u.ack(0);
    tok(7'h05, 1'h0);
    chk({31'h0, resp_en}, 32'h0);
    // Bus reset drops the address, keeps the enable
    bus(1'h1, 12'h800, 32'h8a);
    host_u.ack(0);
    host_u.bus_reset(2);
    rd(12'h800, 32'h80);
    chk({25'h0, act}, 32'h0);
    tok(7'h00, 1'h1);
    // Soft reset through the mode word clears both fields
    bus(1'h1, 12'h800, 32'h91);
    host_u.ack(1);
    bus(1'h1, 12'h830, 32'h10);
    rd(12'h800, 32'h0);
    chk({25'h0, act}, 32'h0);
    chk({31'h0, resp_en}, 32'h0);
    // Byte lanes: only lane 0 reaches the scratch word and the address register
    @(posedge clk_in);
    avs_byteenable_in <= 4'h1;
    bus(1'h1, 12'h9e0, 32'h0000abcd);
    rd(12'h9e0, 32'h56cd);
    @(posedge clk_in);
    avs_byteenable_in <= 4'he;
    bus(1'h1, 12'h800, 32'h85);
    rd(12'h800, 32'h0);
    chk({31'h0, pend}, 32'h0);
    @(posedge clk_in);
    avs_byteenable_in <= 4'hf;
    // Power-on reset in mid-run, with a live active address
    bus(1'h1, 12'h800, 32'hff);
    host_u.ack(0);
    chk({25'h0, act}, 32'h7f);
    @(posedge clk_in);
    rst_in <= 1'h1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'h0;
    rd(12'h800, 32'h0);
    chk({31'h0, pend}, 32'h0);
    chk({25'h0, act}, 32'h0);
    chk({31'h0, resp_en}, 32'h0);
    rd(12'h9e0, 32'h0);
    end_sim();
  end
endmodule
bind usb_device_address_register usb_addr_props #(.ADDR_W(ADDR_W)) props_u (
  .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .usb_bus_reset_in(usb_bus_reset_in),
  .status_ack_in(status_ack_in), .token_valid_in(token_valid_in),
  .token_addr_in(token_addr_in), .token_match_out(token_match_out),
  .respond_enable_out(respond_enable_out), .active_addr_out(active_addr_out),
  .addr_pending_out(addr_pending_out));
